/* File: sfpe_pkg.sv */
// constants and types shared by the serial flash program and erase sequencer
package sfpe_pkg;

	// ------------------------------------------------------------
	// command opcodes
	// ------------------------------------------------------------
	localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
	localparam logic [7:0] OP_PAGE_PROG = 8'h02;
	localparam logic [7:0] OP_PAGE_PROG_4B = 8'h12;
	localparam logic [7:0] OP_QUAD_PROG = 8'h32;
	localparam logic [7:0] OP_QUAD_PROG_ALT = 8'h38;
	localparam logic [7:0] OP_QUAD_PROG_4B = 8'h34;
	localparam logic [7:0] OP_PROG_SUSPEND = 8'h85;
	localparam logic [7:0] OP_PROG_RESUME = 8'h8a;
	localparam logic [7:0] OP_PARAM_ERASE = 8'h20;
	localparam logic [7:0] OP_PARAM_ERASE_4B = 8'h21;
	localparam logic [7:0] OP_READ_STATUS1 = 8'h05;
	localparam logic [7:0] OP_READ_STATUS2 = 8'h07;

	// ------------------------------------------------------------
	// status bit positions
	// ------------------------------------------------------------
	localparam int SR1_WIP = 0;
	localparam int SR1_WEL = 1;
	localparam int SR1_E_ERR = 5;
	localparam int SR1_P_ERR = 6;
	localparam int SR2_PROG_SUSP = 0;
	localparam int SR2_PAGE_512 = 6;

	// ------------------------------------------------------------
	// apb register map and fields
	// ------------------------------------------------------------
	localparam logic [11:0] REG_CFG = 12'h000;
	localparam logic [11:0] REG_PROT = 12'h004;
	localparam logic [11:0] REG_STAT = 12'h008;
	localparam int CFG_EXT_ADDR = 0;
	localparam int CFG_QUAD = 1;
	localparam int CFG_PAGE_512 = 2;
	localparam int CFG_SECT_256K = 3;
	localparam logic [3:0] CFG_RESET = 4'h0;
	localparam logic [19:0] PROT_RESET = 20'h00000;
	localparam int STAT_SR2_LSB = 8;

	// ------------------------------------------------------------
	// frame geometry
	// ------------------------------------------------------------
	localparam logic [5:0] BITS_CMD_LAST = 6'h07;
	localparam logic [5:0] BITS_ADDR3_LAST = 6'h17;
	localparam logic [5:0] BITS_ADDR4_LAST = 6'h1f;
	localparam logic [8:0] PAGE_MASK_256 = 9'h0ff;
	localparam logic [8:0] PAGE_MASK_512 = 9'h1ff;
	localparam int SECT_4K_LSB = 12;

	// ------------------------------------------------------------
	// timing, clock 5 ns
	// ------------------------------------------------------------
	localparam int T_CLK_NS = 5;
	localparam int T_PROG_NS = 1000;
	localparam int T_ERASE_NS = 10000;
	localparam int T_SUSP_LAT_NS = 200;
	localparam int PROG_CYC = (T_PROG_NS + T_CLK_NS - 1) / T_CLK_NS;
	localparam int ERASE_CYC = (T_ERASE_NS + T_CLK_NS - 1) / T_CLK_NS;
	localparam int SUSP_LAT_CYC = (T_SUSP_LAT_NS / T_CLK_NS < 1) ? 1 : T_SUSP_LAT_NS / T_CLK_NS;

	// ------------------------------------------------------------
	// state types
	// ------------------------------------------------------------
	typedef enum logic [2:0] {FR_CMD, FR_ADDR, FR_DATA, FR_TAIL, FR_END, FR_READ, FR_IGN} sfpe_frame_t;
	typedef enum logic [2:0] {OP_IDLE, OP_PROG, OP_ERASE, OP_SUSP_PEND, OP_SUSP} sfpe_op_t;

endpackage : sfpe_pkg

/* File: sfpe_page_buf.sv */
// page buffer memory with registered read data
`timescale 1ns/1ps
`default_nettype none
module sfpe_page_buf #(
	parameter int DEPTH = 512,
	parameter int WIDTH = 8
) (
	// clock
	input wire logic pclk,
	// write port
	input wire logic we,
	input wire logic [$clog2(DEPTH)-1:0] waddr,
	input wire logic [WIDTH-1:0] wdata,
	// read port
	input wire logic [$clog2(DEPTH)-1:0] raddr,
	output logic [WIDTH-1:0] rdata_q
);
	logic [WIDTH-1:0] mem [DEPTH];

	// write and registered read
	always_ff @(posedge pclk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
		rdata_q <= mem[raddr];
	end
endmodule : sfpe_page_buf
`default_nettype wire

/* File: sfpe_top.sv */
// serial flash program, suspend, resume and parameter erase sequencer
// Notes on behaviour
// - page is 256 or 512 bytes, chosen by status two bit 6
// - pages align to page size; one program changes bits in one page only
// - page program accepted only with the write enable latch set
// - 02h takes 3 or 4 address bytes by setting, 12h four; data follows
// - data past page end wraps to offset zero of the same page
// - more than a page overwrites earlier bytes; last page-worth programmed
// - short loads leave other page bytes unchanged; bits only go 1 to 0
// - busy bit reads 1 while programming; bit 6 flags program failure
// - quad opcodes 32h, 38h by setting, 34h four bytes; nibble data
// - quad program needs quad enable and the write enable latch
// - quad program closes the whole page; unfilled bytes stay ones
// - suspend 85h honoured only while programming runs
// - status reads 05h and 07h accepted while suspend takes effect
// - status two bit 0 tells suspended from completed
// - resume 8Ah ignored unless programming is suspended
// - accepted resume sets busy bit and continues programming
// - 20h by setting, 21h four bytes; ignored with 256-kB sector option
// - erase starts only on select rising right after last address bit
// - erase needs write enable; busy bit reads 1 until done
// - protected sector sets erase error; non-4-kB sector ignored silently
`timescale 1ns/1ps
`default_nettype none
module sfpe_top import sfpe_pkg::*; #(
	parameter int PAGE_MAX = 512,
	parameter int PARAM_SECTS = 16
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic [11:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// serial flash pins
	input wire logic cs_n,
	input wire logic sck,
	input wire logic [3:0] io_in,
	output logic [3:0] io_out,
	output logic [3:0] io_oe,
	// array side
	input wire logic [8:0] buf_raddr,
	output logic [7:0] buf_rdata,
	output logic arr_prog,
	output logic arr_erase,
	output logic arr_quad,
	output logic [31:0] arr_addr
);
	// ------------------------------------------------------------
	// elaboration checks
	// ------------------------------------------------------------
	if (PAGE_MAX != 512) begin : g_bad_page
		$error("page buffer must hold 512 bytes");
	end
	if (PARAM_SECTS < 1 || PARAM_SECTS > 4096) begin : g_bad_sects
		$error("parameter sector count out of range");
	end

	// ------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------
	logic cs_m_q, cs_s_q, cs_p_q, sck_m_q, sck_s_q, sck_p_q;
	logic [3:0] io_m_q, io_s_q;
	logic sck_rise, sck_fall, cs_rise, cs_act;
	sfpe_frame_t fr_q;
	sfpe_op_t op_q;
	logic [5:0] cnt_q;
	logic [7:0] sh_q, cmd_q, rd_sh_q;
	logic [31:0] addr_q;
	logic [8:0] off_q;
	logic got_byte_q, quad_q, four_b_q, is_erase_q, dbit_q;
	logic [3:0] cfg_q;
	logic [19:0] prot_q;
	logic wel_q, p_err_q, e_err_q, psus_q;
	logic [15:0] tmr_q;
	logic [15:0] lat_q;
	logic [PAGE_MAX-1:0] valid_q;
	logic valid_rd_q;
	logic [7:0] mem_rdata;
	logic [7:0] cmd_byte, sr1, sr2, data_byte;
	logic [8:0] pmask;
	logic [31:0] addr_nx;
	logic [5:0] alast;
	logic write_in_progress, busy_ok, byte_done, buf_we, valid_clr, acc_wr, stat_clr;
	logic start_prog, start_erase, prot_fail, erase_ok, do_susp, do_resume, prog_done;
	logic is_prog_op, is_quad_op, is_erase_op, is_4b_op;

	// ------------------------------------------------------------
	// pin synchronisers and edge detect
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cs_m_q <= 1'b1;
			cs_s_q <= 1'b1;
			cs_p_q <= 1'b1;
			sck_m_q <= 1'b0;
			sck_s_q <= 1'b0;
			sck_p_q <= 1'b0;
			io_m_q <= 4'h0;
			io_s_q <= 4'h0;
		end else begin
			cs_m_q <= cs_n;
			cs_s_q <= cs_m_q;
			cs_p_q <= cs_s_q;
			sck_m_q <= sck;
			sck_s_q <= sck_m_q;
			sck_p_q <= sck_s_q;
			io_m_q <= io_in;
			io_s_q <= io_m_q;
		end
	end
	assign cs_act = !cs_s_q;
	assign sck_rise = cs_act && sck_s_q && !sck_p_q;
	assign sck_fall = cs_act && !sck_s_q && sck_p_q;
	assign cs_rise = cs_s_q && !cs_p_q;

	// ------------------------------------------------------------
	// decode helpers
	// ------------------------------------------------------------
	assign write_in_progress = (op_q != OP_IDLE) && (op_q != OP_SUSP);
	assign sr1 = {1'b0, p_err_q, e_err_q, 3'h0, wel_q, write_in_progress};
	assign sr2 = {1'b0, cfg_q[CFG_PAGE_512], 5'h00, psus_q};
	assign cmd_byte = {sh_q[6:0], io_s_q[0]};
	assign pmask = cfg_q[CFG_PAGE_512] ? PAGE_MASK_512 : PAGE_MASK_256;
	assign addr_nx = {addr_q[30:0], io_s_q[0]};
	assign alast = (four_b_q || cfg_q[CFG_EXT_ADDR]) ? BITS_ADDR4_LAST : BITS_ADDR3_LAST;
	assign data_byte = quad_q ? {sh_q[3:0], io_s_q} : cmd_byte;
	assign byte_done = sck_rise && fr_q == FR_DATA && (quad_q ? dbit_q : cnt_q[2:0] == 3'h7);
	assign is_prog_op = cmd_byte == OP_PAGE_PROG || cmd_byte == OP_PAGE_PROG_4B;
	assign is_quad_op = cmd_byte == OP_QUAD_PROG || cmd_byte == OP_QUAD_PROG_ALT
		|| cmd_byte == OP_QUAD_PROG_4B;
	assign is_erase_op = cmd_byte == OP_PARAM_ERASE || cmd_byte == OP_PARAM_ERASE_4B;
	assign is_4b_op = cmd_byte == OP_PAGE_PROG_4B || cmd_byte == OP_QUAD_PROG_4B
		|| cmd_byte == OP_PARAM_ERASE_4B;
	assign busy_ok = op_q == OP_IDLE;

	// ------------------------------------------------------------
	// frame sequencer on the serial clock
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fr_q <= FR_CMD;
			cnt_q <= 6'h00;
			sh_q <= 8'h00;
			cmd_q <= 8'h00;
			addr_q <= 32'h0;
			off_q <= 9'h000;
			got_byte_q <= 1'b0;
			quad_q <= 1'b0;
			four_b_q <= 1'b0;
			is_erase_q <= 1'b0;
			dbit_q <= 1'b0;
		end else if (!cs_act) begin
			fr_q <= FR_CMD;
			cnt_q <= 6'h00;
			dbit_q <= 1'b0;
		end else if (sck_rise) begin
			cnt_q <= cnt_q + 6'h01;
			sh_q <= quad_q && fr_q == FR_DATA ? {sh_q[3:0], io_s_q} : cmd_byte;
			unique case (fr_q)
				FR_CMD: begin
					if (cnt_q == BITS_CMD_LAST) begin
						cnt_q <= 6'h00;
						cmd_q <= cmd_byte;
						addr_q <= 32'h0;
						got_byte_q <= 1'b0;
						quad_q <= 1'b0;
						four_b_q <= is_4b_op;
						is_erase_q <= is_erase_op;
						if (cmd_byte == OP_READ_STATUS1 || cmd_byte == OP_READ_STATUS2) begin
							fr_q <= FR_READ;
						end else if (busy_ok && wel_q && (is_prog_op || is_erase_op)) begin
							fr_q <= FR_ADDR;
						end else if (busy_ok && wel_q && is_quad_op && cfg_q[CFG_QUAD]) begin
							fr_q <= FR_ADDR;
						end else if (is_prog_op || is_erase_op || is_quad_op) begin
							fr_q <= FR_IGN;
						end else begin
							fr_q <= FR_END;
						end
					end
				end
				FR_ADDR: begin
					addr_q <= addr_nx;
					if (cnt_q == alast) begin
						cnt_q <= 6'h00;
						off_q <= addr_nx[8:0] & pmask;
						quad_q <= !is_erase_q && cmd_q != OP_PAGE_PROG && cmd_q != OP_PAGE_PROG_4B;
						fr_q <= is_erase_q ? FR_TAIL : FR_DATA;
					end
				end
				FR_DATA: begin
					dbit_q <= !dbit_q;
					if (byte_done) begin
						got_byte_q <= 1'b1;
						off_q <= (off_q + 9'h001) & pmask;
					end
				end
				FR_TAIL, FR_END: fr_q <= FR_IGN;
				FR_READ, FR_IGN: fr_q <= fr_q;
			endcase
		end
	end

	// ------------------------------------------------------------
	// status read out on the falling serial clock
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rd_sh_q <= 8'h00;
			io_out <= 4'h0;
			io_oe <= 4'h0;
		end else if (!cs_act) begin
			io_oe <= 4'h0;
			io_out <= 4'h0;
		end else if (sck_rise && fr_q == FR_CMD && cnt_q == BITS_CMD_LAST) begin
			rd_sh_q <= cmd_byte == OP_READ_STATUS2 ? sr2 : sr1;
		end else if (sck_fall && fr_q == FR_READ) begin
			io_oe <= 4'h2;
			io_out <= {2'h0, rd_sh_q[7], 1'b0};
			rd_sh_q <= {rd_sh_q[6:0], rd_sh_q[7]};
		end
	end

	// ------------------------------------------------------------
	// page buffer and loaded-byte map
	// ------------------------------------------------------------
	assign buf_we = byte_done;
	assign valid_clr = sck_rise && fr_q == FR_ADDR && cnt_q == alast;
	sfpe_page_buf #(.DEPTH(PAGE_MAX), .WIDTH(8)) u_buf (
		.pclk(pclk),
		.we(buf_we),
		.waddr(off_q),
		.wdata(data_byte),
		.raddr(buf_raddr),
		.rdata_q(mem_rdata)
	);
	for (genvar i = 0; i < PAGE_MAX; i++) begin : g_valid
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				valid_q[i] <= 1'b0;
			end else if (valid_clr) begin
				valid_q[i] <= 1'b0;
			end else if (buf_we && off_q == 9'(i)) begin
				valid_q[i] <= 1'b1;
			end
		end
	end
	// unloaded bytes read as ones so the array leaves them unchanged
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			valid_rd_q <= 1'b0;
			buf_rdata <= 8'hff;
		end else begin
			valid_rd_q <= valid_q[buf_raddr];
			buf_rdata <= valid_rd_q ? mem_rdata : 8'hff;
		end
	end

	// ------------------------------------------------------------
	// command execution at select rising
	// ------------------------------------------------------------
	assign prot_fail = addr_q[31:SECT_4K_LSB] < prot_q;
	assign erase_ok = !cfg_q[CFG_SECT_256K] && addr_q[31:SECT_4K_LSB] < 20'(PARAM_SECTS);
	assign start_prog = cs_rise && fr_q == FR_DATA && got_byte_q && !prot_fail;
	assign start_erase = cs_rise && fr_q == FR_TAIL && erase_ok && !prot_fail;
	assign do_susp = cs_rise && fr_q == FR_END && cmd_q == OP_PROG_SUSPEND && op_q == OP_PROG;
	assign do_resume = cs_rise && fr_q == FR_END && cmd_q == OP_PROG_RESUME && op_q == OP_SUSP;
	assign prog_done = (op_q == OP_PROG || op_q == OP_SUSP_PEND) && tmr_q == 16'h0001;
	assign acc_wr = psel && penable && pready && pwrite;
	assign stat_clr = acc_wr && paddr == REG_STAT;

	// ------------------------------------------------------------
	// internal operation engine
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			op_q <= OP_IDLE;
			tmr_q <= 16'h0000;
			lat_q <= 16'h0000;
			psus_q <= 1'b0;
			arr_prog <= 1'b0;
			arr_erase <= 1'b0;
			arr_quad <= 1'b0;
			arr_addr <= 32'h0;
		end else begin
			arr_prog <= 1'b0;
			arr_erase <= 1'b0;
			unique case (op_q)
				OP_IDLE: begin
					if (start_prog) begin
						op_q <= OP_PROG;
						tmr_q <= 16'(PROG_CYC);
						psus_q <= 1'b0;
						arr_quad <= quad_q;
						arr_addr <= addr_q & ~{23'h0, pmask};
					end else if (start_erase) begin
						op_q <= OP_ERASE;
						tmr_q <= 16'(ERASE_CYC);
						psus_q <= 1'b0;
						arr_addr <= {addr_q[31:SECT_4K_LSB], 12'h000};
					end
				end
				OP_PROG: begin
					tmr_q <= tmr_q - 16'h0001;
					if (prog_done) begin
						op_q <= OP_IDLE;
						arr_prog <= 1'b1;
					end else if (do_susp) begin
						op_q <= OP_SUSP_PEND;
						lat_q <= 16'(SUSP_LAT_CYC);
					end
				end
				OP_SUSP_PEND: begin
					tmr_q <= tmr_q - 16'h0001;
					lat_q <= lat_q - 16'h0001;
					if (prog_done) begin
						op_q <= OP_IDLE;
						arr_prog <= 1'b1;
					end else if (lat_q == 16'h0001) begin
						op_q <= OP_SUSP;
						psus_q <= 1'b1;
					end
				end
				OP_SUSP: begin
					if (do_resume) begin
						op_q <= OP_PROG;
						psus_q <= 1'b0;
					end
				end
				OP_ERASE: begin
					tmr_q <= tmr_q - 16'h0001;
					if (tmr_q == 16'h0001) begin
						op_q <= OP_IDLE;
						arr_erase <= 1'b1;
					end
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// write enable latch and error flags, set wins over clear
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wel_q <= 1'b0;
			p_err_q <= 1'b0;
			e_err_q <= 1'b0;
		end else begin
			if (cs_rise && fr_q == FR_END && cmd_q == OP_WRITE_ENABLE && busy_ok) begin
				wel_q <= 1'b1;
			end else if ((op_q == OP_PROG && prog_done) || (op_q == OP_ERASE && tmr_q == 16'h0001)
				|| (cs_rise && (fr_q == FR_DATA || fr_q == FR_TAIL))) begin
				wel_q <= 1'b0;
			end
			if (cs_rise && fr_q == FR_DATA && got_byte_q && prot_fail) begin
				p_err_q <= 1'b1;
			end else if (stat_clr && pwdata[SR1_P_ERR]) begin
				p_err_q <= 1'b0;
			end
			if (cs_rise && fr_q == FR_TAIL && erase_ok && prot_fail) begin
				e_err_q <= 1'b1;
			end else if (stat_clr && pwdata[SR1_E_ERR]) begin
				e_err_q <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// apb slave, one wait state
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0;
			cfg_q <= CFG_RESET;
			prot_q <= PROT_RESET;
		end else begin
			pready <= psel && penable && !pready;
			pslverr <= psel && penable && !pready && paddr != REG_CFG
				&& paddr != REG_PROT && paddr != REG_STAT;
			if (psel && penable && !pready) begin
				unique case (paddr)
					REG_CFG: prdata <= {28'h0, cfg_q};
					REG_PROT: prdata <= {12'h0, prot_q};
					REG_STAT: prdata <= {16'h0, sr2, sr1};
					default: prdata <= 32'h0;
				endcase
			end
			if (acc_wr && paddr == REG_CFG) begin
				cfg_q <= pwdata[3:0];
			end
			if (acc_wr && paddr == REG_PROT) begin
				prot_q <= pwdata[19:0];
			end
		end
	end

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	sequence s_prog_start;
		op_q == OP_IDLE && start_prog;
	endsequence
	sequence s_susp_req;
		op_q == OP_PROG && do_susp && !prog_done;
	endsequence

	a_wel_before_op: assert property (@(posedge pclk) disable iff (!presetn)
		s_prog_start |-> wel_q) else $error("program started without latch");
	a_quad_needs_enable: assert property (@(posedge pclk) disable iff (!presetn)
		s_prog_start and quad_q |-> cfg_q[CFG_QUAD]) else $error("quad without enable");
	a_busy_while_prog: assert property (@(posedge pclk) disable iff (!presetn)
		s_prog_start |=> sr1[SR1_WIP] [*8]) else $error("busy bit not held");
	a_wrap_in_page: assert property (@(posedge pclk) disable iff (!presetn)
		buf_we |-> (off_q & ~pmask) == 9'h000) else $error("write outside page");
	a_suspend_latency: assert property (@(posedge pclk) disable iff (!presetn)
		s_susp_req ##1 (op_q == OP_SUSP_PEND && tmr_q > 16'(SUSP_LAT_CYC + 1))
		|-> ##[1:60] psus_q && !sr1[SR1_WIP]) else $error("suspend not reported");
	a_resume_busy: assert property (@(posedge pclk) disable iff (!presetn)
		op_q == OP_SUSP && do_resume |=> write_in_progress && !psus_q) else $error("resume not busy");
	a_resume_ignored: assert property (@(posedge pclk) disable iff (!presetn)
		op_q == OP_IDLE |=> op_q != OP_PROG || $past(start_prog)) else $error("stray resume");
	a_erase_option: assert property (@(posedge pclk) disable iff (!presetn)
		op_q == OP_IDLE && start_erase |-> !cfg_q[CFG_SECT_256K]) else $error("erase despite option");
	a_erase_flag: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(e_err_q) |-> $past(cs_rise) && $past(erase_ok)) else $error("erase flag set wrongly");
	a_no_latch_no_flag: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(p_err_q) |-> $past(wel_q)) else $error("flag set with latch clear");

endmodule : sfpe_top
`default_nettype wire

/* File: sfpe_spi_host.sv */
// host side serial controller model driving the flash link pins
`timescale 1ns/1ps
`default_nettype none
module sfpe_spi_host (
	// link pins toward the device
	output logic cs_n,
	output logic sck,
	output logic [3:0] io_in,
	// status line back from the device
	input wire logic [3:0] io_out
);
	// idle link: deselected, clock parked low
	initial begin
		cs_n = 1'b1;
		sck = 1'b0;
		io_in = 4'h0;
	end
	// one byte, msb first on io0, or two nibbles on io3..io0
	task automatic send_byte(input logic [7:0] b, input bit quad);
		for (int i = 7; i >= 0; i -= (quad ? 4 : 1)) begin
			io_in = quad ? b[i -: 4] : {~io_in[3:1], b[i]};
			#32 sck = 1'b1;
			#32 sck = 1'b0;
		end
	endtask : send_byte
	// whole frame; bytes from qstart on go four bits per clock
	task automatic frame(input logic [7:0] q [$], input int qstart, input bit extra);
		cs_n = 1'b0;
		#32;
		foreach (q[k]) send_byte(q[k], k >= qstart);
		if (extra) begin
			#32 sck = 1'b1;
			#32 sck = 1'b0;
		end
		#32 cs_n = 1'b1;
		io_in = ~io_in;
		// short gap so a suspend can still land early in a program
		#64;
	endtask : frame
	// status read; released inputs toggle so no stale level lingers
	task automatic status(input logic [7:0] op, output logic [7:0] v);
		cs_n = 1'b0;
		#32;
		send_byte(op, 1'b0);
		for (int i = 7; i >= 0; i--) begin
			io_in = ~io_in;
			#32 v[i] = io_out[1];
			sck = 1'b1;
			#32 sck = 1'b0;
		end
		#32 cs_n = 1'b1;
		#200;
	endtask : status
endmodule : sfpe_spi_host
`default_nettype wire

/* File: tb.sv */
// self-checking bench for the flash program and erase sequencer
`timescale 1ns/1ps
`default_nettype none
module tb import sfpe_pkg::*; ;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, arr_addr;
	logic [8:0] buf_raddr = 9'h000;
	logic pready, pslverr, arr_prog, arr_erase, arr_quad, cs_n, sck;
	logic [3:0] io_in, io_out, io_oe;
	logic [7:0] buf_rdata, v;
	logic [7:0] pd [257];
	logic [7:0] q [$];
	logic [7:0] qops [3] = '{OP_QUAD_PROG, OP_QUAD_PROG_ALT, OP_QUAD_PROG_4B};
	logic [32:0] exp_q [$];
	logic [31:0] arr_q [$];
	int miscompares = 0, num_checks = 0, oe_cycles = 0;
	// 200 MHz clock
	always #2.5 pclk = ~pclk;
	sfpe_top uut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .cs_n(cs_n), .sck(sck), .io_in(io_in),
		.io_out(io_out), .io_oe(io_oe), .buf_raddr(buf_raddr), .buf_rdata(buf_rdata),
		.arr_prog(arr_prog), .arr_erase(arr_erase), .arr_quad(arr_quad), .arr_addr(arr_addr));
	sfpe_spi_host host (.cs_n(cs_n), .sck(sck), .io_in(io_in), .io_out(io_out));
	task automatic check(input string what, input logic [32:0] seen, input logic [32:0] exp);
		num_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic results();
		$display("checks %0d miscompares %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : results
	// each answer is matched with the oldest note; an unnoted event fails
	always @(posedge pclk) begin
		if (io_oe === 4'h2) oe_cycles++;
		if (pready === 1'b1 && pwrite === 1'b0) begin
			check("apb read", {pslverr, prdata}, exp_q.size() ? exp_q.pop_front() : 33'h1ffffffff);
		end
		if (arr_prog === 1'b1 || arr_erase === 1'b1) begin
			check("array base", {1'b0, arr_addr}, arr_q.size() ? {1'b0, arr_q.pop_front()} : 33'h1ffffffff);
		end
	end
	task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d, input logic [32:0] e);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		if (!w) exp_q.push_back(e);
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		psel <= 1'b0;
		penable <= 1'b0;
		if (n == 20) begin
			check("apb timeout", 33'h1, 33'h0);
			results();
		end
	endtask : apb
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(a, 1'b1, d, 33'h0);
	endtask : wr
	task automatic write_enable_cmd();
		host.frame({OP_WRITE_ENABLE}, 99, 1'b0);
	endtask : write_enable_cmd
	task automatic sr(input logic [7:0] op, input logic [7:0] m, input logic [7:0] e);
		int n0;
		n0 = oe_cycles;
		host.status(op, v);
		check("status byte", {25'h0, v & m}, {25'h0, e});
		check("read drive", {32'h0, oe_cycles > n0}, 33'h1);
		check("drive off", {29'h0, io_oe}, 33'h0);
	endtask : sr
	task automatic bc(input logic [8:0] i, input logic [7:0] e);
		@(posedge pclk);
		buf_raddr <= i;
		repeat (3) @(posedge pclk);
		check("page buffer", {25'h0, buf_rdata}, {25'h0, e});
	endtask : bc
	// bounded wait until every noted array event has shown up
	task automatic wq();
		int n;
		for (n = 0; n < 3000 && arr_q.size() > 0; n++) @(posedge pclk);
		if (n == 3000) begin
			check("completion timeout", 33'h1, 33'h0);
			results();
		end
	endtask : wq
	// main sequence
	initial begin
		void'($urandom(32'h6f0cfb09));
		foreach (pd[i]) pd[i] = 8'($urandom);
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		repeat (4) @(posedge pclk);
		apb(REG_CFG, 1'b0, 32'h0, 33'h0);
		apb(REG_PROT, 1'b0, 32'h0, 33'h0);
		apb(12'h00c, 1'b0, 32'h0, 33'h100000000);
		host.frame({OP_PAGE_PROG, 8'h00, 8'h00, 8'h10, 8'h5a}, 99, 1'b0);
		host.frame({OP_PROG_RESUME}, 99, 1'b0);
		sr(OP_READ_STATUS1, 8'hff, 8'h00);
		wr(REG_CFG, 32'h4);
		sr(OP_READ_STATUS2, 8'h40, 8'h40);
		write_enable_cmd();
		sr(OP_READ_STATUS1, 8'h02, 8'h02);
		arr_q.push_back(32'h0);
		host.frame({OP_PAGE_PROG, 8'h00, 8'h01, 8'hfe, pd[0], pd[1], pd[2]}, 99, 1'b0);
		sr(OP_READ_STATUS1, 8'h01, 8'h01);
		wq();
		bc(9'h1ff, pd[1]);
		bc(9'h000, pd[2]);
		bc(9'h001, 8'hff);
		wr(REG_CFG, 32'h0);
		write_enable_cmd();
		arr_q.push_back(32'h200);
		host.frame({OP_PAGE_PROG_4B, 8'h00, 8'h00, 8'h02, 8'h00, pd[3]}, 99, 1'b0);
		host.frame({OP_PROG_SUSPEND}, 99, 1'b0);
		sr(OP_READ_STATUS2, 8'h01, 8'h01);
		sr(OP_READ_STATUS1, 8'h01, 8'h00);
		host.frame({OP_PROG_RESUME}, 99, 1'b0);
		// bus read, quick enough to see the short remainder still busy
		apb(REG_STAT, 1'b0, 32'h0, 33'h001);
		wq();
		foreach (qops[i]) begin
			write_enable_cmd();
			host.frame({qops[i], 8'h00, 8'h00, 8'h00, 8'h00, 8'h00}, 4, 1'b0);
		end
		sr(OP_READ_STATUS1, 8'h01, 8'h00);
		write_enable_cmd();
		host.frame({OP_PAGE_PROG, 8'h00, 8'h04, 8'h00}, 99, 1'b0);
		sr(OP_READ_STATUS1, 8'h01, 8'h00);
		wr(REG_CFG, 32'h3);
		write_enable_cmd();
		q = {OP_QUAD_PROG, 8'h00, 8'h00, 8'h03, 8'h00};
		foreach (pd[i]) q.push_back(pd[i]);
		arr_q.push_back(32'h300);
		host.frame(q, 5, 1'b0);
		wq();
		bc(9'h000, pd[256]);
		bc(9'h001, pd[1]);
		check("quad close", {32'h0, arr_quad}, 33'h1);
		wr(REG_CFG, 32'h0);
		write_enable_cmd();
		arr_q.push_back(32'h1000);
		host.frame({OP_PARAM_ERASE_4B, 8'h00, 8'h00, 8'h10, 8'h00}, 99, 1'b0);
		sr(OP_READ_STATUS1, 8'h01, 8'h01);
		wq();
		write_enable_cmd();
		host.frame({OP_PARAM_ERASE, 8'h00, 8'h20, 8'h00}, 99, 1'b1);
		sr(OP_READ_STATUS1, 8'h01, 8'h00);
		wr(REG_PROT, 32'h1);
		write_enable_cmd();
		host.frame({OP_PARAM_ERASE, 8'h00, 8'h00, 8'h00}, 99, 1'b0);
		write_enable_cmd();
		host.frame({OP_PAGE_PROG, 8'h00, 8'h00, 8'h00, pd[4]}, 99, 1'b0);
		apb(REG_STAT, 1'b0, 32'h0, 33'h60);
		wr(REG_STAT, 32'h60);
		wr(REG_PROT, 32'h0);
		wr(REG_CFG, 32'h8);
		write_enable_cmd();
		host.frame({OP_PARAM_ERASE, 8'h00, 8'h30, 8'h00}, 99, 1'b0);
		sr(OP_READ_STATUS1, 8'h61, 8'h00);
		repeat (2100) @(posedge pclk);
		results();
	end
endmodule : tb
`default_nettype wire
